// ==== verilog/asc_pkg.sv ====
// Constants for the converter scan configuration register bank
// Function
// - Auto-scan: command reads always carry status
// - Fixed mode: command status undefined, direct none
// - Idle select: 0 standby, 1 sleep, reset sleep
// - Bits 6..4 switch delay before conversion, reset 000
// - Bias field: 0 off, 1 1.5uA, 3 24uA
// - Auto-scan rate table per rate code
// - Fixed-channel rate table, scales with master clock
// - Delay or chopping lowers rate below nominal
// - Fixed select: upper nibble positive, lower negative
// - Fixed select only effective in fixed mode
// - Differential enable n measures pair 2n, 2n+1
// - Single-ended channels measured against common input
// - Sequencer converts only enabled channels, except disabled pair 0 after reset until the first restart or advance
// - Scan select writes reset the channel pointer
// - Direction bit 0 output, 1 input; reset inputs
// - Scan mode select: 0 auto-scan, 1 fixed
// - Status enable: 1 allow, 0 suppress where permitted
package asc_pkg;
    localparam logic [3:0] ADDR_CONV_SETUP = 4'h1;
    localparam logic [3:0] ADDR_FIXED_SEL = 4'h2;
    localparam logic [3:0] ADDR_DIFF_EN = 4'h3;
    localparam logic [3:0] ADDR_SINGLE_LO = 4'h4;
    localparam logic [3:0] ADDR_SINGLE_HI = 4'h5;
    localparam logic [3:0] ADDR_SYS_READ = 4'h6;
    localparam logic [3:0] ADDR_PIN_DIR = 4'h7;

    localparam logic [7:0] RST_CONV_SETUP = 8'h83;
    localparam logic [7:0] RST_FIXED_SEL = 8'h00;
    localparam logic [7:0] RST_DIFF_EN = 8'h00;
    localparam logic [7:0] RST_SINGLE_LO = 8'hff;
    localparam logic [7:0] RST_SINGLE_HI = 8'hff;
    localparam logic [7:0] RST_PIN_DIR = 8'hff;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    localparam int IDLE_BIT = 7;
    localparam int DELAY_MSB = 6;
    localparam int DELAY_LSB = 4;
    localparam int BIAS_MSB = 3;
    localparam int BIAS_LSB = 2;
    localparam int RATE_MSB = 1;
    localparam int RATE_LSB = 0;
    localparam int POS_MSB = 7;
    localparam int POS_LSB = 4;
    localparam int NEG_MSB = 3;
    localparam int NEG_LSB = 0;

    localparam logic [1:0] BIAS_OFF = 2'h0;
    localparam logic [1:0] BIAS_1P5 = 2'h1;
    localparam logic [1:0] BIAS_24 = 2'h3;

    localparam int NUM_DIFF = 8;
    localparam int NUM_SINGLE = 16;
    localparam int NUM_CHAN = 24;

    localparam logic [16:0] AUTO_RATE_3 = 17'h0_5cbb;
    localparam logic [16:0] AUTO_RATE_2 = 17'h0_3b13;
    localparam logic [16:0] AUTO_RATE_1 = 17'h0_1818;
    localparam logic [16:0] AUTO_RATE_0 = 17'h0_0727;
    localparam logic [16:0] FIXED_RATE_3 = 17'h1_e848;
    localparam logic [16:0] FIXED_RATE_2 = 17'h0_7a12;
    localparam logic [16:0] FIXED_RATE_1 = 17'h0_1e85;
    localparam logic [16:0] FIXED_RATE_0 = 17'h0_07a1;

    localparam logic [15:0] DELAY_STEP_CYCLES = 16'h0010;

    typedef enum logic [1:0] {
        ASC_ST_IDLE = 2'b01,
        ASC_ST_WAIT = 2'b10
    } asc_state_t;
endpackage

// ==== verilog/asc_scan_seq.sv ====
// Auto-scan channel pointer over the enabled channels
`timescale 1ns/1ps
module asc_scan_seq #(
    parameter int NCH = 24
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [NCH-1:0] chan_enable,
    input wire logic restart,
    input wire logic advance,
    output logic [4:0] chan_q,
    output logic chan_valid_q
);
    logic [4:0] first_idx;
    logic [4:0] next_idx;
    logic any_enabled;

    function automatic logic [4:0] next_enabled(
        input logic [4:0] cur,
        input logic [NCH-1:0] en
    );
        logic [4:0] res;
        int idx;
        res = cur;
        for (int i = NCH; i >= 1; i--) begin
            idx = (int'(cur) + i) % NCH;
            if (en[idx]) begin
                res = 5'(idx);
            end
        end
        return res;
    endfunction

    assign any_enabled = |chan_enable;
    assign first_idx = next_enabled(5'(NCH - 1), chan_enable);
    assign next_idx = next_enabled(chan_q, chan_enable);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            chan_q <= 5'h00;
        end else if (restart) begin
            chan_q <= first_idx;
        end else if (advance) begin
            chan_q <= next_idx;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            chan_valid_q <= 1'b0;
        end else begin
            chan_valid_q <= any_enabled;
        end
    end
endmodule

// ==== verilog/asc_config_regs.sv ====
// Scan configuration register bank with channel and status control
`timescale 1ns/1ps
module asc_config_regs #(
    parameter logic [15:0] DELAY_STEP = asc_pkg::DELAY_STEP_CYCLES
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic scan_mode_select,
    input wire logic status_enable,
    input wire logic chop_enable,
    input wire logic data_read_start,
    input wire logic data_read_by_command,
    input wire logic convert_request,
    input wire logic channel_advance,
    output logic status_byte_include,
    output logic status_byte_undefined,
    output logic idle_state_select,
    output logic [2:0] switch_delay,
    output logic bias_on_1p5,
    output logic bias_on_24,
    output logic [1:0] rate_select,
    output logic [16:0] nominal_rate_sps,
    output logic rate_below_nominal,
    output logic [3:0] mux_pos_sel,
    output logic [3:0] mux_neg_sel,
    output logic neg_is_common,
    output logic diff_channel,
    output logic channel_valid,
    output logic conversion_start,
    output logic [7:0] gpio_output_enable
);
    import asc_pkg::*;

    logic [7:0] conv_setup_q;
    logic [7:0] fixed_sel_q;
    logic [7:0] diff_en_q;
    logic [7:0] single_lo_q;
    logic [7:0] single_hi_q;
    logic [7:0] pin_dir_q;
    logic [7:0] rdata_q;

    logic wr_conv;
    logic wr_fixed;
    logic wr_diff;
    logic wr_lo;
    logic wr_hi;
    logic wr_sys;
    logic wr_dir;
    logic scan_restart;
    logic restart_q;
    logic [7:0] rdata_d;

    assign wr_conv = reg_wr && (reg_addr == ADDR_CONV_SETUP);
    assign wr_fixed = reg_wr && (reg_addr == ADDR_FIXED_SEL);
    assign wr_diff = reg_wr && (reg_addr == ADDR_DIFF_EN);
    assign wr_lo = reg_wr && (reg_addr == ADDR_SINGLE_LO);
    assign wr_hi = reg_wr && (reg_addr == ADDR_SINGLE_HI);
    assign wr_sys = reg_wr && (reg_addr == ADDR_SYS_READ);
    assign wr_dir = reg_wr && (reg_addr == ADDR_PIN_DIR);
    assign scan_restart = wr_diff || wr_lo || wr_hi || wr_sys;

    // Restart one cycle late so the pointer sees the new enables
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            restart_q <= 1'b0;
        end else begin
            restart_q <= scan_restart;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            conv_setup_q <= RST_CONV_SETUP;
        end else if (wr_conv) begin
            conv_setup_q <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            fixed_sel_q <= RST_FIXED_SEL;
        end else if (wr_fixed) begin
            fixed_sel_q <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            diff_en_q <= RST_DIFF_EN;
        end else if (wr_diff) begin
            diff_en_q <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            single_lo_q <= RST_SINGLE_LO;
        end else if (wr_lo) begin
            single_lo_q <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            single_hi_q <= RST_SINGLE_HI;
        end else if (wr_hi) begin
            single_hi_q <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pin_dir_q <= RST_PIN_DIR;
        end else if (wr_dir) begin
            pin_dir_q <= reg_wdata;
        end
    end

    // Register readback
    always_comb begin
        rdata_d = READ_UNMAPPED;
        unique case (reg_addr)
            ADDR_CONV_SETUP: rdata_d = conv_setup_q;
            ADDR_FIXED_SEL: rdata_d = fixed_sel_q;
            ADDR_DIFF_EN: rdata_d = diff_en_q;
            ADDR_SINGLE_LO: rdata_d = single_lo_q;
            ADDR_SINGLE_HI: rdata_d = single_hi_q;
            ADDR_PIN_DIR: rdata_d = pin_dir_q;
            default: rdata_d = READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= READ_UNMAPPED;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // Status byte inclusion
    logic include_d;
    logic undefined_d;
    logic include_q;
    logic undefined_q;

    assign include_d = scan_mode_select ? data_read_by_command
                                        : (data_read_by_command || status_enable);
    assign undefined_d = scan_mode_select && data_read_by_command;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            include_q <= 1'b0;
            undefined_q <= 1'b0;
        end else if (data_read_start) begin
            include_q <= include_d;
            undefined_q <= undefined_d;
        end
    end

    assign status_byte_include = include_q;
    assign status_byte_undefined = undefined_q;

    // Conversion setup decode
    logic [1:0] bias_code;
    logic [1:0] rate_code;
    logic [2:0] delay_code;
    logic [16:0] rate_d;
    logic idle_q;
    logic [2:0] delay_q;
    logic bias_1p5_q;
    logic bias_24_q;
    logic [1:0] rate_q;
    logic [16:0] rate_sps_q;
    logic below_q;

    assign bias_code = conv_setup_q[BIAS_MSB:BIAS_LSB];
    assign rate_code = conv_setup_q[RATE_MSB:RATE_LSB];
    assign delay_code = conv_setup_q[DELAY_MSB:DELAY_LSB];

    function automatic logic [16:0] rate_lookup(input logic fixed, input logic [1:0] code);
        logic [16:0] r;
        r = AUTO_RATE_0;
        unique case (code)
            2'h3: r = fixed ? FIXED_RATE_3 : AUTO_RATE_3;
            2'h2: r = fixed ? FIXED_RATE_2 : AUTO_RATE_2;
            2'h1: r = fixed ? FIXED_RATE_1 : AUTO_RATE_1;
            2'h0: r = fixed ? FIXED_RATE_0 : AUTO_RATE_0;
        endcase
        return r;
    endfunction

    assign rate_d = rate_lookup(scan_mode_select, rate_code);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            idle_q <= 1'b1;
            delay_q <= 3'h0;
            bias_1p5_q <= 1'b0;
            bias_24_q <= 1'b0;
            rate_q <= 2'h3;
            rate_sps_q <= AUTO_RATE_3;
            below_q <= 1'b0;
        end else begin
            idle_q <= conv_setup_q[IDLE_BIT];
            delay_q <= delay_code;
            bias_1p5_q <= (bias_code == BIAS_1P5);
            bias_24_q <= (bias_code == BIAS_24);
            rate_q <= rate_code;
            rate_sps_q <= rate_d;
            below_q <= (delay_code != 3'h0) || chop_enable;
        end
    end

    assign idle_state_select = idle_q;
    assign switch_delay = delay_q;
    assign bias_on_1p5 = bias_1p5_q;
    assign bias_on_24 = bias_24_q;
    assign rate_select = rate_q;
    assign nominal_rate_sps = rate_sps_q;
    assign rate_below_nominal = below_q;

    // Auto-scan sequencer
    logic [NUM_CHAN-1:0] chan_en;
    logic [4:0] seq_chan;
    logic seq_valid;
    logic seq_advance;

    assign chan_en = {single_hi_q, single_lo_q, diff_en_q};
    assign seq_advance = channel_advance && !scan_mode_select;

    asc_scan_seq #(
        .NCH(NUM_CHAN)
    ) u_seq (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .chan_enable(chan_en),
        .restart(restart_q),
        .advance(seq_advance),
        .chan_q(seq_chan),
        .chan_valid_q(seq_valid)
    );

    // Channel to multiplexer selection
    logic seq_is_diff;
    logic [3:0] single_idx;
    logic [3:0] auto_pos;
    logic [3:0] auto_neg;
    logic [3:0] pos_d;
    logic [3:0] neg_d;
    logic common_d;
    logic diff_d;
    logic valid_d;

    assign seq_is_diff = (seq_chan < 5'(NUM_DIFF));
    assign single_idx = 4'(seq_chan - 5'(NUM_DIFF));
    assign auto_pos = seq_is_diff ? {seq_chan[2:0], 1'b0} : single_idx;
    assign auto_neg = seq_is_diff ? {seq_chan[2:0], 1'b1} : 4'h0;
    assign pos_d = scan_mode_select ? fixed_sel_q[POS_MSB:POS_LSB] : auto_pos;
    assign neg_d = scan_mode_select ? fixed_sel_q[NEG_MSB:NEG_LSB] : auto_neg;
    assign common_d = !scan_mode_select && !seq_is_diff;
    assign diff_d = !scan_mode_select && seq_is_diff;
    assign valid_d = scan_mode_select || seq_valid;

    logic [3:0] pos_q;
    logic [3:0] neg_q;
    logic common_q;
    logic diff_q;
    logic valid_q;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pos_q <= 4'h0;
            neg_q <= 4'h0;
            common_q <= 1'b0;
            diff_q <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            pos_q <= pos_d;
            neg_q <= neg_d;
            common_q <= common_d;
            diff_q <= diff_d;
            valid_q <= valid_d;
        end
    end

    assign mux_pos_sel = pos_q;
    assign mux_neg_sel = neg_q;
    assign neg_is_common = common_q;
    assign diff_channel = diff_q;
    assign channel_valid = valid_q;

    // Switch delay before conversion start
    asc_state_t state_q;
    asc_state_t state_d;
    logic [18:0] wait_q;
    logic [18:0] wait_d;
    logic [18:0] delay_total;
    logic start_d;
    logic start_q;

    assign delay_total = 19'(delay_code) * 19'(DELAY_STEP);

    always_comb begin
        state_d = state_q;
        wait_d = wait_q;
        start_d = 1'b0;
        unique case (state_q)
            ASC_ST_IDLE: begin
                if (convert_request && valid_d) begin
                    if (delay_total == 19'h0_0000) begin
                        start_d = 1'b1;
                    end else begin
                        wait_d = delay_total - 19'h0_0001;
                        state_d = ASC_ST_WAIT;
                    end
                end
            end
            ASC_ST_WAIT: begin
                if (wait_q == 19'h0_0000) begin
                    start_d = 1'b1;
                    state_d = ASC_ST_IDLE;
                end else begin
                    wait_d = wait_q - 19'h0_0001;
                end
            end
            default: begin
                state_d = ASC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ASC_ST_IDLE;
            wait_q <= 19'h0_0000;
            start_q <= 1'b0;
        end else begin
            state_q <= state_d;
            wait_q <= wait_d;
            start_q <= start_d;
        end
    end

    assign conversion_start = start_q;

    // Pin direction
    logic [7:0] oe_q;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            oe_q <= 8'h00;
        end else begin
            oe_q <= ~pin_dir_q;
        end
    end

    assign gpio_output_enable = oe_q;
endmodule

// ==== tb/asc_config_checker.sv ====
// Concurrent checks on the configuration register bank ports
`timescale 1ns/1ps
module asc_config_checker
    import asc_pkg::*;
#(
    parameter logic [15:0] DELAY_STEP = asc_pkg::DELAY_STEP_CYCLES
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic scan_mode_select,
    input wire logic status_enable,
    input wire logic chop_enable,
    input wire logic data_read_start,
    input wire logic data_read_by_command,
    input wire logic convert_request,
    input wire logic channel_advance,
    input wire logic status_byte_include,
    input wire logic status_byte_undefined,
    input wire logic idle_state_select,
    input wire logic [2:0] switch_delay,
    input wire logic bias_on_1p5,
    input wire logic bias_on_24,
    input wire logic [1:0] rate_select,
    input wire logic [16:0] nominal_rate_sps,
    input wire logic rate_below_nominal,
    input wire logic [3:0] mux_pos_sel,
    input wire logic [3:0] mux_neg_sel,
    input wire logic neg_is_common,
    input wire logic diff_channel,
    input wire logic channel_valid,
    input wire logic conversion_start,
    input wire logic [7:0] gpio_output_enable
);
    localparam int CONV_LAT = DELAY_STEP + 1;
    wire logic setup_wr = reg_wr && reg_addr == ADDR_CONV_SETUP;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    a_setup_fields: assert property (
        setup_wr |-> ##2 idle_state_select == $past(reg_wdata[7], 2) && rate_select ==
        $past(reg_wdata[1:0], 2) && switch_delay == $past(reg_wdata[6:4], 2))
        else $error("setup fields not applied");
    a_bias_decode: assert property (setup_wr |-> ##2
        bias_on_1p5 == ($past(reg_wdata[3:2], 2) == 2'h1)
        && bias_on_24 == ($past(reg_wdata[3:2], 2) == 2'h3)) else $error("bias decode wrong");
    a_below_nominal: assert property ($stable(switch_delay) |->
        rate_below_nominal == (switch_delay != 3'h0 || $past(chop_enable)))
        else $error("rate below nominal flag wrong");
    a_fixed_inputs: assert property (
        reg_wr && reg_addr == ADDR_FIXED_SEL ##1 scan_mode_select ##1 scan_mode_select |->
        mux_pos_sel == $past(reg_wdata[7:4], 2) && mux_neg_sel == $past(reg_wdata[3:0], 2))
        else $error("fixed input selection wrong");
    a_status_incl: assert property (data_read_start |=> status_byte_include ==
        $past(data_read_by_command || status_enable && !scan_mode_select))
        else $error("status byte inclusion wrong");
    a_status_undef: assert property (data_read_start |=> status_byte_undefined ==
        $past(data_read_by_command && scan_mode_select)) else $error("status undefined wrong");
    a_diff_pair: assert property (diff_channel && !scan_mode_select &&
        $past(!scan_mode_select) |-> !mux_pos_sel[0] && !neg_is_common &&
        mux_neg_sel == mux_pos_sel + 4'h1) else $error("differential pair wrong");
    a_single_common: assert property (neg_is_common |->
        mux_neg_sel == 4'h0 && !diff_channel) else $error("common input selection wrong");
    a_gpio_dir: assert property (reg_wr && reg_addr == ADDR_PIN_DIR |-> ##2
        gpio_output_enable == ~$past(reg_wdata, 2)) else $error("pin direction wrong");
    a_conv_delay: assert property (convert_request && switch_delay == 3'h1 &&
        $stable(switch_delay) && channel_valid |-> ##CONV_LAT conversion_start)
        else $error("conversion start late or missing");
endmodule

bind asc_config_regs asc_config_checker #(.DELAY_STEP(DELAY_STEP)) asc_config_checker_inst (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .scan_mode_select(scan_mode_select), .status_enable(status_enable),
    .chop_enable(chop_enable), .data_read_start(data_read_start),
    .data_read_by_command(data_read_by_command), .convert_request(convert_request),
    .channel_advance(channel_advance), .status_byte_include(status_byte_include),
    .status_byte_undefined(status_byte_undefined), .idle_state_select(idle_state_select),
    .switch_delay(switch_delay), .bias_on_1p5(bias_on_1p5), .bias_on_24(bias_on_24),
    .rate_select(rate_select), .nominal_rate_sps(nominal_rate_sps),
    .rate_below_nominal(rate_below_nominal), .mux_pos_sel(mux_pos_sel),
    .mux_neg_sel(mux_neg_sel), .neg_is_common(neg_is_common), .diff_channel(diff_channel),
    .channel_valid(channel_valid), .conversion_start(conversion_start),
    .gpio_output_enable(gpio_output_enable)
);

// ==== tb/asc_host_model.sv ====
// Host controller model driving the register port
`timescale 1ns/1ps
module asc_host_model (
    input wire logic ref_clk,
    output logic [3:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 4'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // Released lines show the inverse of the last value
    task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = (a == 4'h6) ? (d & 8'h3d) : d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask

    task automatic read_reg(input logic [3:0] a, output logic [7:0] v);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        v = reg_rdata;
        reg_addr = ~reg_addr;
    endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking testbench for the scan configuration register bank
`timescale 1ns/1ps
module tb;
    import asc_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic scan_mode_select = 1'b0;
    logic status_enable = 1'b0;
    logic chop_enable = 1'b0;
    logic data_read_start = 1'b0;
    logic data_read_by_command = 1'b0;
    logic convert_request = 1'b0;
    logic channel_advance = 1'b0;
    logic reg_wr, reg_rd, status_byte_include, status_byte_undefined, idle_state_select;
    logic bias_on_1p5, bias_on_24, rate_below_nominal, neg_is_common, diff_channel;
    logic channel_valid, conversion_start;
    logic [1:0] rate_select;
    logic [2:0] switch_delay;
    logic [3:0] reg_addr, mux_pos_sel, mux_neg_sel;
    logic [7:0] reg_wdata, reg_rdata, gpio_output_enable;
    logic [16:0] nominal_rate_sps;
    int miscompares = 0;
    int total_checks = 0;

    always #2 ref_clk = ~ref_clk;

    asc_config_regs #(.DELAY_STEP(16'h0002)) asc_config_regs_inst (
        .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .scan_mode_select(scan_mode_select), .status_enable(status_enable),
        .chop_enable(chop_enable), .data_read_start(data_read_start),
        .data_read_by_command(data_read_by_command), .convert_request(convert_request),
        .channel_advance(channel_advance), .status_byte_include(status_byte_include),
        .status_byte_undefined(status_byte_undefined), .idle_state_select(idle_state_select),
        .switch_delay(switch_delay), .bias_on_1p5(bias_on_1p5), .bias_on_24(bias_on_24),
        .rate_select(rate_select), .nominal_rate_sps(nominal_rate_sps),
        .rate_below_nominal(rate_below_nominal), .mux_pos_sel(mux_pos_sel),
        .mux_neg_sel(mux_neg_sel), .neg_is_common(neg_is_common), .diff_channel(diff_channel),
        .channel_valid(channel_valid), .conversion_start(conversion_start),
        .gpio_output_enable(gpio_output_enable)
    );
    asc_host_model asc_host_model_inst (
        .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
    );

    task automatic finish_test;
        if (miscompares == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        asc_host_model_inst.write_reg(a, d);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] v;
        asc_host_model_inst.read_reg(a, v);
        chk(v, e);
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
        step(1);
    endtask

    task automatic chk_mux(input logic [3:0] p, input logic [3:0] n);
        chk(mux_pos_sel, p);
        chk(mux_neg_sel, n);
    endtask

    task automatic t_reset_vals;
        logic [7:0] e [8] = '{8'h00, 8'h83, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'hff};
        chk({idle_state_select, switch_delay, bias_on_1p5, bias_on_24, rate_select}, 8'h83);
        chk(gpio_output_enable, 8'h00);
        for (int a = 0; a < 8; a++) begin
            rd_chk(4'(a), e[a]);
        end
        rd_chk(4'hf, 8'h00);
    endtask

    task automatic t_setup;
        logic [16:0] rt [2][4] = '{'{17'h0_0727, 17'h0_1818, 17'h0_3b13, 17'h0_5cbb},
            '{17'h0_07a1, 17'h0_1e85, 17'h0_7a12, 17'h1_e848}};
        logic [1:0] c;
        logic [7:0] d;
        for (int m = 0; m < 2; m++) begin
            for (int k = 0; k < 4; k++) begin
                c = 2'(k);
                d = {c[0], 1'b0, c, c, c};
                scan_mode_select = m[0];
                wr(ADDR_CONV_SETUP, d);
                step(2);
                rd_chk(ADDR_CONV_SETUP, d);
                chk({idle_state_select, switch_delay, rate_select}, {c[0], 1'b0, c, c});
                chk({bias_on_1p5, bias_on_24}, {c == 2'h1, c == 2'h3});
                chk(nominal_rate_sps, rt[m][k]);
                chk(rate_below_nominal, c != 2'h0);
            end
        end
        scan_mode_select = 1'b0;
    endtask

    task automatic t_status;
        logic [2:0] i;
        for (int k = 0; k < 8; k++) begin
            i = 3'(k);
            {scan_mode_select, data_read_by_command, status_enable} = i;
            pulse(data_read_start);
            chk(status_byte_include, i[1] | (!i[2] & i[0]));
            chk(status_byte_undefined, i[1] & i[2]);
        end
        scan_mode_select = 1'b0;
    endtask

    task automatic t_scan;
        wr(ADDR_SINGLE_LO, 8'h01);
        wr(ADDR_SINGLE_HI, 8'h00);
        wr(ADDR_DIFF_EN, 8'h04);
        step(2);
        chk_mux(4'h4, 4'h5);
        chk(diff_channel, 1'b1);
        pulse(channel_advance);
        chk_mux(4'h0, 4'h0);
        chk(neg_is_common, 1'b1);
        pulse(channel_advance);
        chk_mux(4'h4, 4'h5);
        pulse(channel_advance);
        wr(ADDR_SYS_READ, 8'h00);
        step(2);
        chk_mux(4'h4, 4'h5);
        wr(ADDR_FIXED_SEL, 8'ha3);
        step(2);
        chk_mux(4'h4, 4'h5);
        scan_mode_select = 1'b1;
        step(2);
        chk_mux(4'ha, 4'h3);
        pulse(channel_advance);
        wr(ADDR_FIXED_SEL, 8'h3c);
        step(2);
        chk_mux(4'h3, 4'hc);
        scan_mode_select = 1'b0;
    endtask

    task automatic t_convert;
        wr(ADDR_DIFF_EN, 8'h01);
        wr(ADDR_CONV_SETUP, 8'h13);
        step(2);
        convert_request = 1'b1;
        step(1);
        convert_request = 1'b0;
        for (int k = 1; k < 5; k++) begin
            step(1);
            chk(conversion_start, k == 2);
        end
        wr(ADDR_CONV_SETUP, 8'h03);
        step(2);
        convert_request = 1'b1;
        step(1);
        chk(conversion_start, 1'b1);
        step(1);
        chk(conversion_start, 1'b1);
        convert_request = 1'b0;
        chop_enable = 1'b1;
        step(2);
        chk(rate_below_nominal, 1'b1);
        chop_enable = 1'b0;
        wr(ADDR_DIFF_EN, 8'h00);
        wr(ADDR_SINGLE_LO, 8'h00);
        step(2);
        chk(channel_valid, 1'b0);
        convert_request = 1'b1;
        step(1);
        chk(conversion_start, 1'b0);
        convert_request = 1'b0;
    endtask

    task automatic t_gpio;
        wr(ADDR_PIN_DIR, 8'h5a);
        wr(4'h9, 8'h77);
        step(2);
        chk(gpio_output_enable, 8'ha5);
        rd_chk(ADDR_PIN_DIR, 8'h5a);
        rd_chk(4'h9, 8'h00);
    endtask

    initial begin
        step(5);
        resetn = 1'b1;
        step(1);
        t_reset_vals();
        t_setup();
        t_status();
        t_scan();
        t_convert();
        t_gpio();
        finish_test();
    end

    // Run needs well under a thousand cycles
    initial begin
        #20000;
        miscompares++;
        finish_test();
    end
endmodule
